/* File: verilog/mci_top.sv */
// Command intake of one pulse-train motion channel.
`timescale 1ns/100ps
`default_nettype none
module mci_top #(
  parameter int XFER_CYCLES = mci_pkg::XFER_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Motion side
  input  wire logic       halt_req_in,
  input  wire logic       motion_done_in,
  input  wire logic       axis_stopped_in,
  output logic            halt_axis_out,
  output logic            merge_out,
  output logic      [7:0] active_code_out,
  output logic            start_out
);

  // ------------------------------------------------------------------
  // Halt, completion and standstill crossing
  // ------------------------------------------------------------------
  logic halt_sync;
  logic done_sync;
  logic stopped_sync;

  mci_sync2 u_sync_halt (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (halt_req_in),
    .sync_out (halt_sync)
  );

  mci_sync2 u_sync_done (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (motion_done_in),
    .sync_out (done_sync)
  );

  mci_sync2 u_sync_stop (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (axis_stopped_in),
    .sync_out (stopped_sync)
  );

  // ------------------------------------------------------------------
  // Command staging and transfer
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    XF_IDLE  = 2'b00,
    XF_BUSY  = 2'b01,
    XF_DECIDE = 2'b10
  } mci_xfer_type;

  mci_xfer_type          xfer_reg;
  logic            [7:0] code_reg;
  logic            [1:0] mode_reg;
  logic            [7:0] xfer_cnt_reg;
  logic                  fail_reg;
  logic            [6:0] seq_value;
  logic                  send_req;
  logic                  decide;

  assign send_req = wr_in && (addr_in == mci_pkg::ADDR_CMD_SEND);
  assign decide   = (xfer_reg == XF_DECIDE);

  mci_seq_counter u_seq (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .advance_in (decide && !fail_reg),
    .seq_out    (seq_value)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_reg <= 8'h00;
      mode_reg <= 2'h0;
    end else if (wr_in && xfer_reg == XF_IDLE) begin
      if (addr_in == mci_pkg::ADDR_CMD_CODE) begin
        code_reg <= wdata_in;
      end
      if (addr_in == mci_pkg::ADDR_CMD_MODE) begin
        mode_reg <= wdata_in[1:0];
      end
    end
  end

  // A send during a running exchange is dropped without any trace.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xfer_reg     <= XF_IDLE;
      xfer_cnt_reg <= 8'h00;
      fail_reg     <= 1'b0;
    end else begin
      case (xfer_reg)
        XF_IDLE: begin
          if (send_req) begin
            xfer_reg     <= XF_BUSY;
            xfer_cnt_reg <= 8'(XFER_CYCLES);
            fail_reg     <= wdata_in[mci_pkg::SEND_FAIL_BIT];
          end
        end
        XF_BUSY: begin
          if (xfer_cnt_reg <= 8'h01) begin
            xfer_reg <= XF_DECIDE;
          end else begin
            xfer_cnt_reg <= xfer_cnt_reg - 8'h01;
          end
        end
        XF_DECIDE: begin
          xfer_reg <= XF_IDLE;
        end
        default: begin
          xfer_reg <= XF_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Acceptance decision
  // ------------------------------------------------------------------
  mci_pkg::mci_slot_type exec_reg;
  mci_pkg::mci_slot_type queue_reg;
  logic                  exec_valid_reg;
  logic                  queue_valid_reg;
  logic                  stopping_reg;
  logic                  code_ok;
  logic                  is_pos;
  logic                  is_queued_mode;
  logic                  seq_ok;
  logic                  overflow;
  logic                  accept;

  always_comb begin
    code_ok = 1'b0;
    is_pos  = 1'b0;
    case (code_reg)
      mci_pkg::CMD_FREQ,
      mci_pkg::CMD_VELOCITY,
      mci_pkg::CMD_HOMING,
      mci_pkg::CMD_PRESET: begin
        code_ok = 1'b1;
      end
      mci_pkg::CMD_ABSOLUTE,
      mci_pkg::CMD_RELATIVE: begin
        code_ok = 1'b1;
        is_pos  = 1'b1;
      end
      default: begin
        code_ok = 1'b0;
      end
    endcase
  end

  assign is_queued_mode = (mode_reg == mci_pkg::MODE_BUFFERED) ||
                          (mode_reg == mci_pkg::MODE_MERGE);

  // Sequence table of current versus next command.
  always_comb begin
    seq_ok = 1'b0;
    if (!exec_valid_reg) begin
      seq_ok = 1'b1;
    end else if (exec_reg.code == mci_pkg::CMD_HOMING ||
                 exec_reg.code == mci_pkg::CMD_PRESET) begin
      seq_ok = 1'b0;
    end else if (code_reg == mci_pkg::CMD_HOMING || code_reg == mci_pkg::CMD_PRESET) begin
      seq_ok = 1'b0;
    end else if (is_pos && is_queued_mode) begin
      seq_ok = (exec_reg.code == mci_pkg::CMD_ABSOLUTE) ||
               (exec_reg.code == mci_pkg::CMD_RELATIVE);
    end else begin
      seq_ok = 1'b1;
    end
  end

  assign overflow = exec_valid_reg && queue_valid_reg;
  assign accept   = code_ok && !stopping_reg && !halt_sync && !overflow && seq_ok;

  // ------------------------------------------------------------------
  // Executing and queued slots
  // ------------------------------------------------------------------
  logic abort_all;
  logic to_queue;
  logic done_prev_reg;
  logic done_pend_reg;
  logic done_hit;

  assign abort_all = decide && !fail_reg && code_ok && !accept && !halt_sync && !stopping_reg;
  assign to_queue  = exec_valid_reg && is_pos && is_queued_mode && (exec_reg.code != code_reg);
  assign done_hit  = (done_sync && !done_prev_reg) || done_pend_reg;

  // Completion is taken on its rising edge, so the level that lingers through the
  // synchroniser cannot retire the command that starts behind it.
  // An edge that meets a queuing decision waits here for one cycle.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_prev_reg <= 1'b0;
      done_pend_reg <= 1'b0;
    end else begin
      done_prev_reg <= done_sync;
      done_pend_reg <= done_sync && !done_prev_reg && decide && !fail_reg && accept && to_queue;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      exec_reg        <= '0;
      queue_reg       <= '0;
      exec_valid_reg  <= 1'b0;
      queue_valid_reg <= 1'b0;
      start_out       <= 1'b0;
      merge_out       <= 1'b0;
    end else begin
      start_out <= 1'b0;
      if (halt_sync || abort_all) begin
        exec_valid_reg  <= 1'b0;
        queue_valid_reg <= 1'b0;
      end else if (decide && !fail_reg && accept) begin
        if (to_queue) begin
          queue_reg       <= '{mci_pkg::mci_cmd_type'(code_reg),
                               mci_pkg::mci_mode_type'(mode_reg), seq_value};
          queue_valid_reg <= 1'b1;
        end else begin
          // Abort mode, or a command of the active type, replaces at once.
          exec_reg        <= '{mci_pkg::mci_cmd_type'(code_reg),
                               mci_pkg::mci_mode_type'(mode_reg), seq_value};
          exec_valid_reg  <= 1'b1;
          queue_valid_reg <= 1'b0;
          start_out       <= 1'b1;
          merge_out       <= 1'b0;
        end
      end else if (exec_valid_reg && done_hit) begin
        // Buffered waits for completion; merge is flagged to the profile.
        exec_reg        <= queue_reg;
        exec_valid_reg  <= queue_valid_reg;
        queue_valid_reg <= 1'b0;
        start_out       <= queue_valid_reg;
        merge_out       <= queue_valid_reg && (queue_reg.mode == mci_pkg::MODE_MERGE);
      end
    end
  end

  // Stopping lasts from a halt or abort until the halt request is gone and the axis reports standstill.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stopping_reg  <= 1'b0;
      halt_axis_out <= 1'b0;
    end else begin
      if (halt_sync || abort_all) begin
        stopping_reg <= 1'b1;
      end else if (stopped_sync) begin
        stopping_reg <= 1'b0;
      end
      halt_axis_out <= halt_sync || abort_all || (stopping_reg && !stopped_sync);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_code_out <= 8'h00;
    end else begin
      active_code_out <= exec_valid_reg ? exec_reg.code : 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Returned number and flags
  // ------------------------------------------------------------------
  logic [7:0] number_reg;
  logic       success_reg;
  logic       fault_reg;
  logic       badop_reg;
  logic       ovf_reg;
  logic       seqinv_reg;
  logic       flags_clr;
  logic       reject;

  assign flags_clr = wr_in && (addr_in == mci_pkg::ADDR_FLAGS);
  assign reject    = decide && !fail_reg && !accept;

  // One number serves both issue paths.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      number_reg  <= mci_pkg::NUMBER_RESET;
      success_reg <= 1'b0;
    end else if (decide) begin
      if (fail_reg) begin
        number_reg  <= mci_pkg::NUMBER_RESET;
        success_reg <= 1'b0;
      end else if (accept) begin
        number_reg  <= {1'b0, seq_value};
        success_reg <= 1'b1;
      end else begin
        number_reg  <= mci_pkg::REJECT_MASK | {1'b0, seq_value};
        success_reg <= 1'b1;
      end
    end
  end

  // Write-one-to-clear; a setting event in the same cycle wins.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_reg  <= 1'b0;
      badop_reg  <= 1'b0;
      ovf_reg    <= 1'b0;
      seqinv_reg <= 1'b0;
    end else begin
      fault_reg  <= (decide && (fail_reg || !accept)) ||
                    (fault_reg && !(flags_clr && wdata_in[mci_pkg::ST_FAULT_BIT]));
      badop_reg  <= (reject && !code_ok) ||
                    (badop_reg && !(flags_clr && wdata_in[mci_pkg::FL_BADOP_BIT]));
      ovf_reg    <= (reject && code_ok && overflow) ||
                    (ovf_reg && !(flags_clr && wdata_in[mci_pkg::FL_OVF_BIT]));
      seqinv_reg <= (reject && code_ok && !overflow && !seq_ok) ||
                    (seqinv_reg && !(flags_clr && wdata_in[mci_pkg::FL_SEQ_BIT]));
    end
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  logic       idle_bit;
  logic       slot_bit;
  logic [7:0] status_word;

  // Both low while sending or full; 1/0 never shown.
  assign idle_bit = (xfer_reg == XF_IDLE) && !exec_valid_reg;
  assign slot_bit = (xfer_reg == XF_IDLE) && !queue_valid_reg;

  always_comb begin
    status_word = 8'h00;
    status_word[mci_pkg::ST_PENDING_BIT]  = (xfer_reg != XF_IDLE);
    status_word[mci_pkg::ST_IDLE_BIT]     = idle_bit;
    status_word[mci_pkg::ST_SLOT_BIT]     = slot_bit;
    status_word[mci_pkg::ST_FAULT_BIT]    = fault_reg;
    status_word[mci_pkg::ST_ENO_BIT]      = success_reg;
    status_word[mci_pkg::ST_STOPPING_BIT] = stopping_reg;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        mci_pkg::ADDR_CMD_CODE:   rdata_out <= code_reg;
        mci_pkg::ADDR_CMD_MODE:   rdata_out <= {6'h00, mode_reg};
        mci_pkg::ADDR_CMD_NUMBER: rdata_out <= number_reg;
        mci_pkg::ADDR_STATUS:     rdata_out <= status_word;
        mci_pkg::ADDR_FLAGS:      rdata_out <= {5'h00, seqinv_reg, ovf_reg, badop_reg};
        default:                  rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  reject_stopping_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    decide && !fail_reg && stopping_reg |=> number_reg[7])
    else $error("command accepted while stopping");

  accept_number_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    decide && !fail_reg && accept |=> number_reg >= 8'h01 && number_reg <= 8'h7F && success_reg)
    else $error("accepted number out of range");

  reject_number_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reject |=> number_reg >= 8'h81 && fault_reg)
    else $error("rejected number lacks top bit");

  fail_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    decide && fail_reg |=> number_reg == 8'h00 && !success_reg && fault_reg)
    else $error("failed transfer not zero");

  busy_ignore_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    xfer_reg == XF_BUSY && send_req && xfer_cnt_reg > 8'h01 |=> xfer_reg == XF_BUSY)
    else $error("send during transfer not ignored");

  pending_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    xfer_reg == XF_IDLE && send_req |=> status_word[mci_pkg::ST_PENDING_BIT] [*2])
    else $error("pending bit dropped early");

  overflow_abort_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    decide && !fail_reg && code_ok && overflow && !halt_sync && !stopping_reg
      |=> ovf_reg && !exec_valid_reg ##1 halt_axis_out)
    else $error("overflow did not abort");

  queue_slot_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(idle_bit && !slot_bit))
    else $error("idle without free slot");

  bad_code_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    decide && !fail_reg && !code_ok |=> badop_reg && number_reg[7])
    else $error("bad code not flagged");

endmodule
`default_nettype wire

/* File: shared/mci_pkg.sv */
// Package of constants and types for the motion command intake block.
package mci_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD_CODE   = 8'h00;
  localparam logic [7:0] ADDR_CMD_MODE   = 8'h01;
  localparam logic [7:0] ADDR_CMD_SEND   = 8'h02;
  localparam logic [7:0] ADDR_CMD_NUMBER = 8'h03;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_FLAGS      = 8'h05;
  localparam logic [7:0] ADDR_CONTROL    = 8'h06;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SEND_FAIL_BIT   = 0;
  localparam int ST_PENDING_BIT  = 0;
  localparam int ST_IDLE_BIT     = 1;
  localparam int ST_SLOT_BIT     = 2;
  localparam int ST_FAULT_BIT    = 3;
  localparam int ST_ENO_BIT      = 4;
  localparam int ST_STOPPING_BIT = 5;
  localparam int FL_BADOP_BIT    = 0;
  localparam int FL_OVF_BIT      = 1;
  localparam int FL_SEQ_BIT      = 2;
  localparam int CTL_DONE_BIT    = 0;
  localparam int CTL_STOPPED_BIT = 1;

  // ------------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------------
  localparam logic [6:0] SEQ_FIRST        = 7'h01;
  localparam logic [6:0] SEQ_LAST         = 7'h7F;
  localparam logic [7:0] REJECT_MASK      = 8'h80;
  localparam logic [7:0] NUMBER_RESET     = 8'h00;
  localparam int         XFER_TIME_NS     = 40;
  localparam int         CLK_PERIOD_NS    = 4;
  localparam int         XFER_CYCLES      = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Command codes and buffer modes
  // ------------------------------------------------------------------
  typedef enum logic [7:0] {
    CMD_NONE     = 8'h00,
    CMD_FREQ     = 8'h01,
    CMD_VELOCITY = 8'h02,
    CMD_ABSOLUTE = 8'h03,
    CMD_RELATIVE = 8'h04,
    CMD_HOMING   = 8'h05,
    CMD_PRESET   = 8'h06
  } mci_cmd_type;

  typedef enum logic [1:0] {
    MODE_ABORT    = 2'h0,
    MODE_BUFFERED = 2'h1,
    MODE_MERGE    = 2'h2
  } mci_mode_type;

  typedef struct packed {
    mci_cmd_type  code;
    mci_mode_type mode;
    logic [6:0]   seq;
  } mci_slot_type;

endpackage

/* File: verilog/mci_seq_counter.sv */
// Command number generator wrapping from the last number back to the first.
`timescale 1ns/100ps
`default_nettype none
module mci_seq_counter (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic       advance_in,
  // Value
  output logic      [6:0] seq_out
);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_out <= mci_pkg::SEQ_FIRST;
    end else if (advance_in) begin
      if (seq_out == mci_pkg::SEQ_LAST) begin
        seq_out <= mci_pkg::SEQ_FIRST;
      end else begin
        seq_out <= seq_out + 7'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* File: verilog/mci_sync2.sv */
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module mci_sync2 (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

/* File: bench/mci_motion_model.sv */
// Behavioural motion stage that answers the start and halt outputs of the intake block.
`timescale 1ns/100ps
`default_nettype none
module mci_motion_model #(
  parameter int DONE_CYC = 30,
  parameter int STOP_CYC = 40
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // From the block and the bench
  input  wire logic start_in,
  input  wire logic halt_in,
  input  wire logic hold_in,
  // To the block
  output logic      done_out,
  output logic      stopped_out
);
  int run_cnt;
  int stop_cnt;
  // Holding the move keeps it executing, so a later command has to queue.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) run_cnt <= 0;
    else if (start_in) run_cnt <= DONE_CYC;
    else if (run_cnt != 0 && !hold_in) run_cnt <= run_cnt - 1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) stop_cnt <= STOP_CYC;
    else if (!halt_in) stop_cnt <= STOP_CYC;
    else if (stop_cnt != 0) stop_cnt <= stop_cnt - 1;
  end
  assign done_out    = run_cnt != 0 && run_cnt <= 3;
  assign stopped_out = halt_in && stop_cnt == 0;
endmodule
`default_nettype wire

/* File: bench/mci_top_tb.sv */
// Self-checking testbench of the motion command intake block.
`timescale 1ns/100ps
`default_nettype none
module mci_top_tb;
  localparam int XFER = 6;
  logic       clk_in, rst_n_in, wr_in, rd_in, halt_req_in, hold, done, stopped;
  logic       halt_axis_out, merge_out, start_out;
  logic [7:0] addr_in, wdata_in, rdata_out, active_code_out, q;
  logic [6:0] seq;
  int         error_cnt, n_tests;

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  mci_top #(.XFER_CYCLES(XFER)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .halt_req_in(halt_req_in),
    .motion_done_in(done), .axis_stopped_in(stopped), .halt_axis_out(halt_axis_out),
    .merge_out(merge_out), .active_code_out(active_code_out), .start_out(start_out));

  mci_motion_model model_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_out), .halt_in(halt_axis_out),
    .hold_in(hold), .done_out(done), .stopped_out(stopped));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One strobe cycle; read data are taken in the cycle after the strobe.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= w;
    rd_in    <= !w;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    @(negedge clk_in);
    q = rdata_out;
  endtask

  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    for (int i = 0; i < 100; i++) begin
      acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
      if ((q & m) === v) break;
    end
    chk(q & m, v);
  endtask

  task automatic send(input logic [7:0] c, input logic [7:0] m, input logic [7:0] f);
    acc(1'b1, mci_pkg::ADDR_CMD_CODE, c);
    acc(1'b1, mci_pkg::ADDR_CMD_MODE, m);
    acc(1'b1, mci_pkg::ADDR_CMD_SEND, f);
    poll(8'h01, 8'h00);
  endtask

  // Expected number follows the bench's own count, wrapping after the last.
  task automatic num(input logic rej);
    acc(1'b0, mci_pkg::ADDR_CMD_NUMBER, 8'h00);
    chk(q, {rej, seq});
    seq = (seq == 7'h7F) ? 7'h01 : seq + 7'h01;
  endtask

  task automatic clr();
    acc(1'b1, mci_pkg::ADDR_FLAGS, 8'h0F);
    acc(1'b0, mci_pkg::ADDR_FLAGS, 8'h00);
    chk(q & 8'h07, 8'h00);
    acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
    chk(q & 8'h2F, 8'h06);
  endtask

  task automatic wait_free();
    for (int i = 0; i < 200; i++) begin
      @(negedge clk_in);
      if (active_code_out === 8'h00) break;
    end
    chk(active_code_out, 8'h00);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
    chk(q, 8'h06);
    acc(1'b0, mci_pkg::ADDR_CMD_NUMBER, 8'h00);
    chk(q, 8'h00);
    acc(1'b0, 8'h3C, 8'h00);
    chk(q, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_codes();
    for (logic [7:0] c = 8'h01; c <= 8'h06; c++) begin
      send(c, 8'h00, 8'h00);
      num(1'b0);
      acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
      chk(q & 8'h18, 8'h10);
      chk(active_code_out, c);
      wait_free();
      clr();
    end
    $display("test codes done");
  endtask

  task automatic t_bad();
    send(8'h09, 8'h00, 8'h00);
    num(1'b1);
    acc(1'b0, mci_pkg::ADDR_FLAGS, 8'h00);
    chk(q & 8'h01, 8'h01);
    acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
    chk(q & 8'h18, 8'h18);
    clr();
    $display("test bad code done");
  endtask

  task automatic t_fail();
    send(8'h03, 8'h00, 8'h01);
    acc(1'b0, mci_pkg::ADDR_CMD_NUMBER, 8'h00);
    chk(q, 8'h00);
    acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
    chk(q & 8'h18, 8'h08);
    clr();
    $display("test failed transfer done");
  endtask

  task automatic t_queue();
    @(posedge clk_in);
    hold <= 1'b1;
    send(8'h03, 8'h00, 8'h00);
    num(1'b0);
    acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
    chk(q & 8'h07, 8'h04);
    send(8'h04, 8'h01, 8'h00);
    num(1'b0);
    acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
    chk(q & 8'h07, 8'h00);
    send(8'h04, 8'h01, 8'h00);
    num(1'b1);
    acc(1'b0, mci_pkg::ADDR_FLAGS, 8'h00);
    chk(q & 8'h02, 8'h02);
    chk({7'h00, halt_axis_out}, 8'h01);
    @(posedge clk_in);
    hold <= 1'b0;
    poll(8'h20, 8'h00);
    wait_free();
    clr();
    $display("test queue overflow done");
  endtask

  task automatic t_halt();
    @(posedge clk_in);
    halt_req_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    chk({7'h00, halt_axis_out}, 8'h01);
    send(8'h02, 8'h00, 8'h00);
    num(1'b1);
    acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
    chk(q & 8'h20, 8'h20);
    @(posedge clk_in);
    halt_req_in <= 1'b0;
    poll(8'h20, 8'h00);
    clr();
    $display("test halt done");
  endtask

  // A second send lands inside the transfer window and must leave no trace.
  task automatic t_skip();
    acc(1'b1, mci_pkg::ADDR_CMD_CODE, 8'h01);
    acc(1'b1, mci_pkg::ADDR_CMD_MODE, 8'h00);
    acc(1'b1, mci_pkg::ADDR_CMD_SEND, 8'h00);
    acc(1'b1, mci_pkg::ADDR_CMD_SEND, 8'h00);
    acc(1'b0, mci_pkg::ADDR_STATUS, 8'h00);
    chk(q & 8'h01, 8'h01);
    poll(8'h01, 8'h00);
    num(1'b0);
    send(8'h01, 8'h00, 8'h00);
    num(1'b0);
    chk(active_code_out, 8'h01);
    wait_free();
    $display("test ignored send done");
  endtask

  // A merge command waits in the queue, starts flagged after the first move, then a homing
  // command against the running move is refused and aborts everything.
  task automatic t_merge();
    @(posedge clk_in);
    hold <= 1'b1;
    send(8'h03, 8'h00, 8'h00);
    num(1'b0);
    send(8'h04, 8'h02, 8'h00);
    num(1'b0);
    chk(active_code_out, 8'h03);
    chk({7'h00, merge_out}, 8'h00);
    @(posedge clk_in);
    hold <= 1'b0;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk_in);
      if (start_out === 1'b1) break;
    end
    chk({7'h00, start_out}, 8'h01);
    chk({7'h00, merge_out}, 8'h01);
    @(negedge clk_in);
    chk(active_code_out, 8'h04);
    send(8'h05, 8'h00, 8'h00);
    num(1'b1);
    acc(1'b0, mci_pkg::ADDR_FLAGS, 8'h00);
    chk(q & 8'h07, 8'h04);
    chk({7'h00, halt_axis_out}, 8'h01);
    poll(8'h20, 8'h00);
    wait_free();
    clr();
    $display("test merge done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {wr_in, rd_in, halt_req_in, hold, rst_n_in} = 5'h00;
    {addr_in, wdata_in} = 16'h0000;
    seq = 7'h01;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_codes();
    t_bad();
    t_fail();
    t_queue();
    t_halt();
    t_skip();
    t_merge();
    final_report();
  end

  // The scenarios need about 750 cycles; over twenty-five times that means a hang.
  initial begin
    #80000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
